// ### common/scg_pkg.sv
// Register map, field layout and carriers of the sample clock generator
`default_nettype none
package scg_pkg;
   localparam int ADDR_W = 18;
   localparam logic [17:0] OFS_RATE = 18'h04e20;
   localparam logic [17:0] OFS_CLKOUT = 18'h04e8e;
   localparam logic [17:0] OFS_TERM = 18'h04e98;
   localparam logic [17:0] OFS_REFFREQ = 18'h04eac;
   localparam logic [17:0] OFS_MODE = 18'h04ee8;
   localparam logic [17:0] OFS_MODEMASK = 18'h04ee9;
   localparam logic [17:0] OFS_OVSFACT = 18'h30dbb;
   // Mode codes, one-hot
   localparam logic [31:0] PLL_INTERNAL_REF_MODE = 32'h00000001;
   localparam logic [31:0] FIRST_OSCILLATOR_MODE = 32'h00000002;
   localparam logic [31:0] SECOND_OSCILLATOR_MODE = 32'h00000004;
   localparam logic [31:0] PLL_EXTERNAL_REF_MODE = 32'h00000020;
   // Reset values
   localparam logic [31:0] RST_MODE = PLL_INTERNAL_REF_MODE;
   localparam logic [31:0] RST_RATE = 32'h00989680;
   localparam logic [31:0] RST_REFFREQ = 32'h00989680;
   localparam logic [31:0] RST_OVS = 32'h00000001;
   // Rates in Hz and channel masks
   localparam logic [31:0] INT_REF_HZ = 32'h00989680;
   localparam logic [31:0] MIN_RATE_HZ = 32'h000003e8;
   localparam logic [31:0] MAX_SLOW_HZ = 32'h02faf080;
   localparam logic [31:0] MAX_FAST_HZ = 32'h0bebc200;
   localparam logic [31:0] MAX_FAST_MULTI_HZ = 32'h05f5e100;
   localparam logic [3:0] HALF_RATE_CH = 4'ha;
   localparam logic [3:0] RST_CHAN = 4'h1;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [31:0] data;
   } scg_reg_req_type;

   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } scg_reg_rsp_type;

   typedef struct packed {
      logic pllEnable;
      logic pllRefExt;
      logic osc2Select;
      logic [31:0] divider;
      logic [31:0] pllRefHz;
      logic [31:0] sampleHz;
   } scg_clk_cfg_type;
endpackage
`default_nettype wire

// ### hdl/scg_sample_clock.sv
// Sample clock mode control, rate solver, oversampling and clock connector
// Function
// - Mode 1 selects the PLL fed by the internal 10 MHz reference.
// - Mode 2 bypasses the PLL; first oscillator plus divider forms sample clock.
// - Mode 4 selects the optional second oscillator, direct or divided.
// - Mode 32 feeds the PLL from the external connector.
// - Rate register takes desired Hz; reads back nearest achievable rate.
// - Clock output drives the connector, only in internally clocked modes.
// - Programmed rates go down to 1 kS/s in every internal mode.
// - Maximum rate depends on variant and active channels: 50, 200 or 100 MS/s.
// - First-oscillator mode turns the rate into a divider and reports its rate.
// - Second-oscillator mode divides the oscillator for slower rates.
// - External-reference PLL is set from the reference; some rates unreachable.
// - Termination load only switched in while the connector is an input.
// - Below converter minimum, converter runs at a multiple; datapath slower.
// - Oversampling factor register reads current multiple, 1 when inactive.
// - Clock output carries the real converter clock during oversampling.
// - Pipeline compensation on when synchronous, lost while oversampling.
// - Timestamp counts real converter clock ticks.
// - Read-only mask shows the supported mode codes.
`timescale 1ns/1ps
`default_nettype none
module scg_sample_clock
   import scg_pkg::*;
#(
   parameter bit FAST_VARIANT = 1'b1,
   parameter bit OSC2_PRESENT = 1'b0,
   parameter logic [31:0] OSC1_HZ = 32'h0bebc200,
   parameter logic [31:0] OSC2_HZ = 32'h05f5e100,
   parameter logic [31:0] ADC_MIN_HZ = 32'h00989680,
   parameter logic [7:0] PLL_MAX_MULT = 8'h08,
   parameter int TS_W = 48
)
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire scg_reg_req_type regReq,
   output scg_reg_rsp_type regRsp,
   input wire logic [3:0] chanEnable,
   input wire logic adcClkPin,
   output logic extClkO,
   output logic extClkOe_n,
   output logic termOn,
   output scg_clk_cfg_type clkCfg,
   output logic pipeComp,
   output logic dataStrobe,
   output logic [TS_W-1:0] timestamp
);
   // Refused at elaboration, before any logic is built
   if (TS_W < 8 || TS_W > 64 || OSC1_HZ == 32'h0 || ADC_MIN_HZ == 32'h0 || PLL_MAX_MULT == 8'h0)
   begin
      $error("scg_sample_clock: unsupported parameter values");
   end

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_QDIV = 2'b01,
      S_QRATE = 2'b11,
      S_OVS = 2'b10
   } scg_state_type;

   function automatic logic hitReg(input scg_reg_req_type r, input logic [17:0] ofs);
      hitReg = (r.addr == ofs);
   endfunction

   scg_state_type state_q;
   logic [31:0] mode_q, rate_q, ref_q, achieved_q, factor_q;
   logic clkOut_q, term_q, pend_q, adcS1_q, adcS2_q, adcS3_q;
   logic [31:0] dvd_q, dvs_q, quo_q, decCnt_q;
   logic [32:0] rem_q;
   logic [4:0] cnt_q;
   logic [3:0] chan_q;

   // Mode mask and mode write check
   wire [31:0] modeMask = PLL_INTERNAL_REF_MODE | FIRST_OSCILLATOR_MODE | PLL_EXTERNAL_REF_MODE
                        | (OSC2_PRESENT ? SECOND_OSCILLATOR_MODE : 32'h0);
   wire wrMode = regReq.wr && hitReg(regReq, OFS_MODE);
   wire modeOk = (regReq.data != 32'h0) && ((regReq.data & (regReq.data - 32'h1)) == 32'h0)
                 && ((regReq.data & ~modeMask) == 32'h0);
   wire isQ1 = mode_q == FIRST_OSCILLATOR_MODE;
   wire isQ2 = mode_q == SECOND_OSCILLATOR_MODE;
   wire isExt = mode_q == PLL_EXTERNAL_REF_MODE;
   wire isQuartz = isQ1 || isQ2;

   // Rate limits
   wire [31:0] maxVar = !FAST_VARIANT ? MAX_SLOW_HZ
                      : ((chanEnable & HALF_RATE_CH) == 4'h0) ? MAX_FAST_HZ : MAX_FAST_MULTI_HZ;
   wire [39:0] extLim = ref_q * PLL_MAX_MULT;
   wire [31:0] maxRate = (isExt && extLim < {8'h0, maxVar}) ? extLim[31:0] : maxVar;
   wire [31:0] rc = (rate_q < MIN_RATE_HZ) ? MIN_RATE_HZ
                  : (rate_q > maxRate) ? maxRate : rate_q;
   wire [31:0] oscHz = isQ2 ? OSC2_HZ : OSC1_HZ;

   // One restoring division step per cycle
   wire [32:0] remSh = {rem_q[31:0], dvd_q[31]};
   wire [32:0] remSub = remSh - {1'b0, dvs_q};
   wire ge = !remSub[32];
   wire [31:0] quoN = {quo_q[30:0], ge};
   wire divLast = (cnt_q == 5'd31);
   wire [31:0] divN = (quoN == 32'h0) ? 32'h1 : quoN;

   wire wrRate = regReq.wr && hitReg(regReq, OFS_RATE);
   wire wrRef = regReq.wr && hitReg(regReq, OFS_REFFREQ);
   wire recalc = wrRate || wrRef || (wrMode && modeOk) || (chanEnable != chan_q);
   wire start = (state_q == S_IDLE) && pend_q;

   // Connector direction
   wire driveOut = clkOut_q && !isExt;
   wire adcTick = adcS2_q && !adcS3_q;
   wire decWrap = (decCnt_q + 32'h1) >= factor_q;

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         mode_q <= RST_MODE;
         rate_q <= RST_RATE;
         ref_q <= RST_REFFREQ;
         clkOut_q <= 1'b0;
         term_q <= 1'b0;
      end
      else
      begin
         if (wrMode && modeOk)
            mode_q <= regReq.data;
         if (wrRate)
            rate_q <= regReq.data;
         if (wrRef)
            ref_q <= regReq.data;
         if (regReq.wr && hitReg(regReq, OFS_CLKOUT))
            clkOut_q <= regReq.data[0];
         if (regReq.wr && hitReg(regReq, OFS_TERM))
            term_q <= regReq.data[0];
      end
   end

   // Register read port, answer one cycle after the strobe
   wire [31:0] rdMux = hitReg(regReq, OFS_RATE) ? achieved_q
                     : hitReg(regReq, OFS_CLKOUT) ? {31'h0, clkOut_q}
                     : hitReg(regReq, OFS_TERM) ? {31'h0, term_q}
                     : hitReg(regReq, OFS_REFFREQ) ? ref_q
                     : hitReg(regReq, OFS_MODE) ? mode_q
                     : hitReg(regReq, OFS_MODEMASK) ? modeMask
                     : hitReg(regReq, OFS_OVSFACT) ? factor_q : 32'h0;

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
         regRsp <= '0;
      else
      begin
         regRsp.valid <= regReq.rd;
         regRsp.data <= regReq.rd ? rdMux : 32'h0;
      end
   end

   // Rate solver; a new request during a solve is kept and served next
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         state_q <= S_IDLE;
         pend_q <= 1'b1;
         chan_q <= RST_CHAN;
         dvd_q <= 32'h0;
         dvs_q <= 32'h1;
         quo_q <= 32'h0;
         rem_q <= 33'h0;
         cnt_q <= 5'd0;
         achieved_q <= RST_RATE;
         factor_q <= RST_OVS;
         clkCfg <= '0;
      end
      else
      begin
         chan_q <= chanEnable;
         pend_q <= recalc || (pend_q && !start);
         if (state_q != S_IDLE)
         begin
            rem_q <= ge ? remSub : remSh;
            quo_q <= quoN;
            dvd_q <= {dvd_q[30:0], 1'b0};
            cnt_q <= cnt_q + 5'd1;
         end
         case (state_q)
            S_IDLE:
            begin
               if (start)
               begin
                  rem_q <= 33'h0;
                  quo_q <= 32'h0;
                  cnt_q <= 5'd0;
                  dvs_q <= rc;
                  clkCfg.pllEnable <= !isQuartz;
                  clkCfg.pllRefExt <= isExt;
                  clkCfg.osc2Select <= isQ2;
                  clkCfg.pllRefHz <= isExt ? ref_q : INT_REF_HZ;
                  if (isQuartz)
                  begin
                     dvd_q <= oscHz + {1'b0, rc[31:1]};
                     state_q <= S_QDIV;
                  end
                  else
                  begin
                     clkCfg.divider <= 32'h1;
                     achieved_q <= rc;
                     dvd_q <= ADC_MIN_HZ + rc - 32'h1;
                     state_q <= S_OVS;
                  end
               end
            end
            S_QDIV:
            begin
               if (divLast)
               begin
                  clkCfg.divider <= divN;
                  rem_q <= 33'h0;
                  quo_q <= 32'h0;
                  dvs_q <= divN;
                  dvd_q <= oscHz + {1'b0, divN[31:1]};
                  state_q <= S_QRATE;
               end
            end
            S_QRATE:
            begin
               if (divLast)
               begin
                  achieved_q <= quoN;
                  rem_q <= 33'h0;
                  quo_q <= 32'h0;
                  dvs_q <= quoN;
                  dvd_q <= ADC_MIN_HZ + quoN - 32'h1;
                  state_q <= S_OVS;
               end
            end
            S_OVS:
            begin
               if (divLast)
               begin
                  factor_q <= divN;
                  clkCfg.sampleHz <= achieved_q;
                  state_q <= S_IDLE;
               end
            end
            default:
               state_q <= S_IDLE;
         endcase
      end
   end

   // Converter clock domain, decimation, timestamp and connector
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         adcS1_q <= 1'b0;
         adcS2_q <= 1'b0;
         adcS3_q <= 1'b0;
         decCnt_q <= 32'h0;
         dataStrobe <= 1'b0;
         timestamp <= '0;
         extClkO <= 1'b0;
         extClkOe_n <= 1'b1;
         termOn <= 1'b0;
         pipeComp <= 1'b1;
      end
      else
      begin
         adcS1_q <= adcClkPin;
         adcS2_q <= adcS1_q;
         adcS3_q <= adcS2_q;
         dataStrobe <= adcTick && decWrap;
         if (adcTick)
         begin
            timestamp <= timestamp + 1'b1;
            decCnt_q <= decWrap ? 32'h0 : decCnt_q + 32'h1;
         end
         // Real converter clock, not the decimated rate
         extClkO <= driveOut && adcS2_q;
         extClkOe_n <= !driveOut;
         termOn <= term_q && !driveOut;
         pipeComp <= (factor_q == 32'h1);
      end
   end

   a_mode_onehot: assert property (@(posedge clk_sys) disable iff (!resetn)
      (mode_q != 32'h0) && ((mode_q & (mode_q - 32'h1)) == 32'h0) && ((mode_q & ~modeMask) == 32'h0))
      else $error("mode not a single supported code");
   a_mode_reject: assert property (@(posedge clk_sys) disable iff (!resetn)
      (wrMode && !modeOk) |=> $stable(mode_q))
      else $error("bad mode write changed mode");
   a_extref_noout: assert property (@(posedge clk_sys) disable iff (!resetn)
      isExt ##1 isExt |-> extClkOe_n)
      else $error("connector driven in external reference mode");
   a_term_input: assert property (@(posedge clk_sys) disable iff (!resetn)
      termOn |-> extClkOe_n)
      else $error("termination on while connector drives");
   a_ovs_minimum: assert property (@(posedge clk_sys) disable iff (!resetn)
      $fell(state_q == S_OVS) |-> ({32'h0, achieved_q} * factor_q >= {32'h0, ADC_MIN_HZ})
      && ({32'h0, achieved_q} * (factor_q - 32'h1) < {32'h0, ADC_MIN_HZ}))
      else $error("oversampling factor not the least multiple");
   a_pipe_comp: assert property (@(posedge clk_sys) disable iff (!resetn)
      ##1 (pipeComp == ($past(factor_q) == 32'h1)))
      else $error("pipeline compensation wrong for factor");
   a_ts_count: assert property (@(posedge clk_sys) disable iff (!resetn)
      adcTick |=> timestamp == $past(timestamp) + 1'b1)
      else $error("timestamp missed converter tick");
   a_strobe_tick: assert property (@(posedge clk_sys) disable iff (!resetn)
      dataStrobe |-> $past(adcTick) && ($past(factor_q) == 32'h1 || $past(decCnt_q) != 32'h0))
      else $error("data strobe without converter tick");
   a_solve_time: assert property (@(posedge clk_sys) disable iff (!resetn)
      start |-> ##[33:97] (state_q == S_IDLE))
      else $error("rate solve did not finish in time");
   a_rate_bound: assert property (@(posedge clk_sys) disable iff (!resetn)
      ($fell(state_q == S_OVS) && !isQuartz) |-> achieved_q >= MIN_RATE_HZ && achieved_q <= maxVar)
      else $error("achieved rate outside limits");
endmodule
`default_nettype wire

// ### test/scg_connector_model.sv
// Far-side model: converter clock source and connector observer
`timescale 1ns/1ps
`default_nettype none
module scg_connector_model (
   output logic adcClkPin,
   input wire logic extClkO,
   input wire logic extClkOe_n,
   input wire logic termOn
);
   int outRises;
   initial
   begin
      adcClkPin = 1'b0;
      outRises = 0;
   end
   // Odd phase times keep rises off clk_sys posedges; high and low both last over 2 periods
   task automatic ticks(input int n);
      repeat (n)
      begin
         #27 adcClkPin = 1'b1;
         #31 adcClkPin = 1'b0;
      end
   endtask
   // A terminated line is an input, so rises there are not board output
   always @(posedge extClkO)
      if (extClkOe_n === 1'b0 && termOn === 1'b0)
         outRises++;
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking testbench of the sample clock generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import scg_pkg::*;
   logic clk_sys;
   logic resetn;
   scg_reg_req_type regReq;
   scg_reg_rsp_type regRsp;
   logic [3:0] chanEnable;
   logic adcClkPin;
   logic extClkO;
   logic extClkOe_n;
   logic termOn;
   scg_clk_cfg_type clkCfg;
   logic pipeComp;
   logic dataStrobe;
   logic [47:0] timestamp;
   logic [31:0] rdData;
   logic [47:0] tsStart;
   int errorCnt;
   int comparisons;
   int strobeCnt;
   int risesStart;

   scg_sample_clock dut (.clk_sys(clk_sys), .resetn(resetn), .regReq(regReq), .regRsp(regRsp),
      .chanEnable(chanEnable), .adcClkPin(adcClkPin), .extClkO(extClkO), .extClkOe_n(extClkOe_n),
      .termOn(termOn), .clkCfg(clkCfg), .pipeComp(pipeComp), .dataStrobe(dataStrobe),
      .timestamp(timestamp));
   scg_connector_model partner (.adcClkPin(adcClkPin), .extClkO(extClkO), .extClkOe_n(extClkOe_n),
      .termOn(termOn));

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
      if (dataStrobe === 1'b1)
         strobeCnt <= strobeCnt + 1;

   task tally_and_finish;
      if (errorCnt == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic checkBit(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   // Strobe dropped a cycle later so back-to-back calls never reassign it in one step
   task automatic regWrite(input logic [17:0] a, input logic [31:0] d);
      regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
      @(posedge clk_sys);
      regReq <= '0;
      @(posedge clk_sys);
   endtask

   // Answer stands only in the cycle after the strobe is taken
   task automatic regRead(input logic [17:0] a, output logic [31:0] d);
      regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 32'h00000000};
      @(posedge clk_sys);
      regReq <= '0;
      #1;
      checkBit(regRsp.valid, 1'b1, "read answer");
      d = regRsp.data;
      @(posedge clk_sys);
   endtask

   task automatic expectRd(input logic [17:0] a, input logic [31:0] exp);
      regRead(a, rdData);
      check32(rdData, exp, "register read");
   endtask

   // Solver latency is only loosely bounded, so poll the achieved rate
   task automatic waitRate(input logic [31:0] exp);
      for (int i = 0; i < 200; i++)
      begin
         regRead(OFS_RATE, rdData);
         if (rdData === exp)
            break;
      end
      check32(rdData, exp, "achieved rate");
      if (rdData !== exp)
         tally_and_finish;
      // Rate shows before the factor stage ends; let it finish
      repeat (40) @(posedge clk_sys);
   endtask

   task automatic resetValues;
      expectRd(OFS_MODE, PLL_INTERNAL_REF_MODE);
      expectRd(OFS_RATE, RST_RATE);
      expectRd(OFS_OVSFACT, 32'h00000001);
      expectRd(OFS_MODEMASK, 32'h00000023);
      expectRd(18'h00010, 32'h00000000);
      checkBit(pipeComp, 1'b1, "compensation at factor 1");
   endtask

   task automatic modeWrites;
      logic [31:0] wrv [7] = '{32'h2, 32'h3, 32'h4, 32'h0, 32'h20, 32'h8, 32'h1};
      logic [31:0] expv [7] = '{32'h2, 32'h2, 32'h2, 32'h2, 32'h20, 32'h20, 32'h1};
      for (int i = 0; i < 7; i++)
      begin
         regWrite(OFS_MODE, wrv[i]);
         expectRd(OFS_MODE, expv[i]);
      end
   endtask

   task automatic pllRates;
      regWrite(OFS_RATE, 32'h017d7840);
      waitRate(32'h017d7840);
      checkBit(clkCfg.pllEnable, 1'b1, "pll on");
      checkBit(clkCfg.pllRefExt, 1'b0, "internal reference");
      regWrite(OFS_RATE, 32'h000001f4);
      waitRate(MIN_RATE_HZ);
      chanEnable <= 4'h3;
      regWrite(OFS_RATE, 32'h1dcd6500);
      waitRate(MAX_FAST_MULTI_HZ);
      chanEnable <= 4'h5;
      waitRate(MAX_FAST_HZ);
      chanEnable <= 4'h1;
   endtask

   task automatic quartzRates;
      regWrite(OFS_MODE, FIRST_OSCILLATOR_MODE);
      regWrite(OFS_RATE, 32'h01c9c380);
      waitRate(32'h01b3f725);
      check32(clkCfg.divider, 32'h00000007, "divider");
      checkBit(clkCfg.pllEnable, 1'b0, "pll bypassed");
      checkBit(clkCfg.osc2Select, 1'b0, "first oscillator");
      regWrite(OFS_RATE, MIN_RATE_HZ);
      waitRate(MIN_RATE_HZ);
   endtask

   task automatic extRef;
      regWrite(OFS_MODE, PLL_EXTERNAL_REF_MODE);
      regWrite(OFS_REFFREQ, 32'h00989680);
      regWrite(OFS_RATE, 32'h05f5e100);
      waitRate(32'h04c4b400);
      checkBit(clkCfg.pllRefExt, 1'b1, "external reference");
      check32(clkCfg.pllRefHz, 32'h00989680, "reference");
   endtask

   task automatic connector;
      regWrite(OFS_CLKOUT, 32'h00000001);
      regWrite(OFS_TERM, 32'h00000001);
      repeat (2) @(posedge clk_sys);
      #1;
      checkBit(extClkOe_n, 1'b1, "no drive in reference mode");
      checkBit(termOn, 1'b1, "termination as input");
      @(posedge clk_sys);
      regWrite(OFS_MODE, PLL_INTERNAL_REF_MODE);
      repeat (2) @(posedge clk_sys);
      #1;
      checkBit(extClkOe_n, 1'b0, "drive in internal mode");
      checkBit(termOn, 1'b0, "no termination while driving");
      @(posedge clk_sys);
   endtask

   task automatic oversampling;
      regWrite(OFS_RATE, 32'h002dc6c0);
      waitRate(32'h002dc6c0);
      expectRd(OFS_OVSFACT, 32'h00000004);
      checkBit(pipeComp, 1'b0, "compensation lost");
      check32(clkCfg.sampleHz, 32'h002dc6c0, "datapath rate");
      tsStart = timestamp;
      strobeCnt = 0;
      risesStart = partner.outRises;
      partner.ticks(8);
      repeat (8) @(posedge clk_sys);
      check32(32'(timestamp - tsStart), 32'h00000008, "timestamp ticks");
      check32(32'(strobeCnt), 32'h00000002, "decimated strobes");
      check32(32'(partner.outRises - risesStart), 32'h00000008, "output clock rises");
   endtask

   initial
   begin
      resetn = 1'b0;
      regReq = '0;
      chanEnable = RST_CHAN;
      errorCnt = 0;
      comparisons = 0;
      strobeCnt = 0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      resetValues;
      modeWrites;
      pllRates;
      quartzRates;
      extRef;
      connector;
      oversampling;
      tally_and_finish;
   end
endmodule
`default_nettype wire
